// ---- hw/cycle_timing_pkg.sv ----
// Shared types and timing constants for the instruction cycle timing engine
package cycle_timing_pkg;

	localparam int CLK_W       = 9;
	localparam int BUS_W       = 4;
	localparam int SHIFT_W     = 6;
	localparam int OPND_W      = 16;
	localparam int PATTERN_W   = 5;
	localparam int TALLY_W     = 32;

	// Formula constants for the data-dependent operations
	localparam int MUL_BASE         = 38;
	localparam int MUL_STEP         = 2;
	localparam int MUL_WORST        = 70;
	localparam int DIV_SIGNED_MAX   = 158;
	localparam int DIV_UNSIGNED_MAX = 140;
	localparam int DIV_TRIM_SHIFT   = 2;
	localparam int SHIFT_BASE_BW    = 6;
	localparam int SHIFT_BASE_LONG  = 8;
	localparam int SHIFT_STEP       = 2;
	localparam int LONG_BASE_SHORT  = 6;
	localparam int LONG_BASE_RAISED = 8;

	typedef enum logic [5:0] {
		op_sum                  = 6'h00,
		op_difference           = 6'h01,
		op_conjunction          = 6'h02,
		op_disjunction          = 6'h03,
		op_compare              = 6'h04,
		op_exclusive            = 6'h05,
		op_signed_divide        = 6'h06,
		op_unsigned_divide      = 6'h07,
		op_signed_multiply      = 6'h08,
		op_unsigned_multiply    = 6'h09,
		op_immediate_sum        = 6'h0a,
		op_immediate_difference = 6'h0b,
		op_immediate_exclusive  = 6'h0c,
		op_immediate_disjunction = 6'h0d,
		op_immediate_conjunction = 6'h0e,
		op_immediate_compare    = 6'h0f,
		op_quick_sum            = 6'h10,
		op_quick_difference     = 6'h11,
		op_quick_load           = 6'h12,
		op_zero_fill            = 6'h13,
		op_arith_minus          = 6'h14,
		op_arith_minus_extend   = 6'h15,
		op_invert               = 6'h16,
		op_cond_set             = 6'h17,
		op_decimal_minus        = 6'h18,
		op_atomic_test_set      = 6'h19,
		op_test_against_zero    = 6'h1a,
		op_shift_rotate         = 6'h1b,
		op_bit_change           = 6'h1c,
		op_bit_clear            = 6'h1d,
		op_bit_set              = 6'h1e,
		op_bit_test             = 6'h1f,
		op_cond_branch          = 6'h20,
		op_unconditional_branch = 6'h21,
		op_branch_to_subroutine = 6'h22,
		op_decrement_loop_branch = 6'h23
	} op_t;

	typedef enum logic [1:0] {
		sz_byte = 2'h0,
		sz_word = 2'h1,
		sz_long = 2'h2
	} size_t;

	typedef enum logic [1:0] {
		dst_data_reg = 2'h0,
		dst_addr_reg = 2'h1,
		dst_memory   = 2'h2
	} dest_t;

	typedef struct packed {
		op_t                 op;
		size_t               size;
		dest_t               dest;
		logic                src_direct;
		logic                bit_static;
		logic                cond_true;
		logic                disp_word;
		logic                count_expired;
		logic [SHIFT_W-1:0]  shift_count;
		logic [OPND_W-1:0]   operand;
	} req_t;

	typedef struct packed {
		logic [CLK_W-1:0] clocks;
		logic [BUS_W-1:0] reads;
		logic [BUS_W-1:0] writes;
	} cost_t;

	typedef struct packed {
		logic [TALLY_W-1:0] clocks;
		logic [TALLY_W-1:0] reads;
		logic [TALLY_W-1:0] writes;
	} tally_t;

	localparam cost_t COST_NONE = '{clocks: '0, reads: '0, writes: '0};

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_run  = 3'b010,
		st_done = 3'b100
	} state_t;

endpackage : cycle_timing_pkg

// ---- hw/bit_pattern_count.sv ----
// Counts one bits and adjacent bit changes of an operand for multiply timing
module bit_pattern_count #(
	parameter int WIDTH = 16,
	parameter int CNT_W = 5
) (
	input  wire logic [WIDTH-1:0] operand,
	output logic      [CNT_W-1:0] ones,
	output logic      [CNT_W-1:0] changes
);

	// Zero appended below the lowest bit before pairs are compared
	wire logic [WIDTH:0] padded = {operand, 1'b0};

	always_comb begin
		ones    = '0;
		changes = '0;
		for (int i = 0; i < WIDTH; i++) begin
			ones    = ones + CNT_W'(operand[i]);
			changes = changes + CNT_W'(padded[i+1] ^ padded[i]);
		end
	end

endmodule : bit_pattern_count

// ---- hw/instruction_cycle_timing.sv ----
// Instruction cycle timing engine: cost lookup, duration countdown, tallies
//
// Contract
// - Count total clocks per instruction, tally reads and writes separately.
// - Flagged entries add operand locator clocks, reads and writes to base.
// - Sum/difference/and/or: reg 4(1/0); memory 8(1/1), long 12(1/2).
// - Long sum family into registers base six, eight for direct/immediate source.
// - Word sum to addr 8(1/0); compare addr 6; compare data 4 or 6.
// - Exclusive-or to data reg needs data reg source; 4 or 8 clocks.
// - Signed divide at most 158, unsigned at most 140, one read each.
// - Divide fastest to slowest spread stays under ten percent of worst.
// - Multiply takes 38+2n clocks, worst 70 with one read.
// - Unsigned multiply n is the count of one bits in source.
// - Signed multiply n counts bit changes in source with zero appended.
// - Immediate sum family: data 8(2/0)/16(3/0); memory 12(2/1)/20(3/2).
// - Long immediate and/compare data 14(3/0); immediate compare memory 8 or 12.
// - Quick add/subtract and quick load timings per destination and size.
// - Clear, negate, negate-extend, invert: reg 4/6; memory 8(1/1)/12(1/2).
// - Conditional set 4/6, decimal minus 6, test-and-set 14(2/1), test 4.
// - Register shifts and rotates take 6+2n or 8+2n with one read.
// - Memory shifts word only, 8(1/1) plus locator time.
// - Register bit ops: change/set 8/12, clear 10/14, test 6/10.
// - Memory bit ops: 8(1/1) or 12(2/1); test 4(1/0) or 8(2/0).
// - Branch taken 10(2/0), not taken 8(1/0)/12(2/0), subroutine 18(2/2).
// - Loop branch: true 12, false looping 10, expired 14(3/0).
module instruction_cycle_timing
	import cycle_timing_pkg::*;
(
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	input  wire logic                      req_valid,
	input  wire cycle_timing_pkg::req_t    req,
	input  wire cycle_timing_pkg::cost_t   locator_cost,
	output logic                           req_ready,
	output logic                           busy,
	output logic                           done,
	output logic                           illegal,
	output cycle_timing_pkg::cost_t        cost,
	output logic [cycle_timing_pkg::PATTERN_W-1:0] duration_n,
	output cycle_timing_pkg::tally_t       tally
);
	import cycle_timing_pkg::*;

	function automatic cost_t mk(input int c, input int r, input int w);
		cost_t v;
		v.clocks = CLK_W'(c);
		v.reads  = BUS_W'(r);
		v.writes = BUS_W'(w);
		return v;
	endfunction : mk

	function automatic cost_t add_cost(input cost_t a, input cost_t b);
		cost_t v;
		v.clocks = a.clocks + b.clocks;
		v.reads  = a.reads + b.reads;
		v.writes = a.writes + b.writes;
		return v;
	endfunction : add_cost

	// Base figures; COST_NONE marks a combination that does not exist
	function automatic cost_t base_cost(input req_t q, input int mul_n, input int div_trim);
		cost_t c;
		logic  lng;
		logic  mem;
		logic  dreg;
		logic  areg;
		c    = COST_NONE;
		lng  = (q.size == sz_long);
		mem  = (q.dest == dst_memory);
		dreg = (q.dest == dst_data_reg);
		areg = (q.dest == dst_addr_reg);
		case (q.op)
			op_sum, op_difference, op_conjunction, op_disjunction: begin
				if (mem)
					c = lng ? mk(12, 1, 2) : mk(8, 1, 1);
				else if (dreg)
					c = lng ? mk(q.src_direct ? LONG_BASE_RAISED : LONG_BASE_SHORT, 1, 0)
						: mk(4, 1, 0);
				else if (areg && (q.op == op_sum || q.op == op_difference)
						&& q.size != sz_byte)
					c = lng ? mk(q.src_direct ? LONG_BASE_RAISED : LONG_BASE_SHORT, 1, 0)
						: mk(8, 1, 0);
			end
			op_compare: begin
				if (areg && q.size != sz_byte)
					c = mk(6, 1, 0);
				else if (dreg)
					c = lng ? mk(6, 1, 0) : mk(4, 1, 0);
			end
			op_exclusive: begin
				if (mem)
					c = lng ? mk(12, 1, 2) : mk(8, 1, 1);
				else if (dreg && q.src_direct)
					c = lng ? mk(8, 1, 0) : mk(4, 1, 0);
			end
			op_signed_divide: begin
				if (dreg)
					c = mk(DIV_SIGNED_MAX - div_trim, 1, 0);
			end
			op_unsigned_divide: begin
				if (dreg)
					c = mk(DIV_UNSIGNED_MAX - div_trim, 1, 0);
			end
			op_signed_multiply, op_unsigned_multiply: begin
				if (dreg)
					c = mk(MUL_BASE + MUL_STEP * mul_n, 1, 0);
			end
			op_immediate_sum, op_immediate_difference, op_immediate_exclusive,
			op_immediate_disjunction, op_immediate_conjunction: begin
				if (dreg && lng && q.op == op_immediate_conjunction)
					c = mk(14, 3, 0);
				else if (dreg)
					c = lng ? mk(16, 3, 0) : mk(8, 2, 0);
				else if (mem)
					c = lng ? mk(20, 3, 2) : mk(12, 2, 1);
			end
			op_immediate_compare: begin
				if (dreg)
					c = lng ? mk(14, 3, 0) : mk(8, 2, 0);
				else if (mem)
					c = lng ? mk(12, 3, 0) : mk(8, 2, 0);
			end
			op_quick_sum, op_quick_difference: begin
				if (dreg)
					c = lng ? mk(8, 1, 0) : mk(4, 1, 0);
				else if (areg && q.size != sz_byte)
					c = (lng || q.op == op_quick_difference) ? mk(8, 1, 0)
						: mk(4, 1, 0);
				else if (mem)
					c = lng ? mk(12, 1, 2) : mk(8, 1, 1);
			end
			op_quick_load: begin
				if (dreg && lng)
					c = mk(4, 1, 0);
			end
			op_zero_fill, op_arith_minus, op_arith_minus_extend, op_invert: begin
				if (dreg)
					c = lng ? mk(6, 1, 0) : mk(4, 1, 0);
				else if (mem)
					c = lng ? mk(12, 1, 2) : mk(8, 1, 1);
			end
			op_cond_set: begin
				if (dreg && q.size == sz_byte)
					c = q.cond_true ? mk(6, 1, 0) : mk(4, 1, 0);
				else if (mem && q.size == sz_byte)
					c = mk(8, 1, 1);
			end
			op_decimal_minus: begin
				if (dreg && q.size == sz_byte)
					c = mk(6, 1, 0);
				else if (mem && q.size == sz_byte)
					c = mk(8, 1, 1);
			end
			op_atomic_test_set: begin
				if (dreg && q.size == sz_byte)
					c = mk(4, 1, 0);
				else if (mem && q.size == sz_byte)
					c = mk(14, 2, 1);
			end
			op_test_against_zero: begin
				if (dreg || mem)
					c = mk(4, 1, 0);
			end
			op_shift_rotate: begin
				if (dreg)
					c = lng ? mk(SHIFT_BASE_LONG + SHIFT_STEP * int'(q.shift_count), 1, 0)
						: mk(SHIFT_BASE_BW + SHIFT_STEP * int'(q.shift_count), 1, 0);
				else if (mem && q.size == sz_word)
					c = mk(8, 1, 1);
			end
			op_bit_change, op_bit_set, op_bit_clear: begin
				if (dreg && lng)
					c = (q.op == op_bit_clear)
						? (q.bit_static ? mk(14, 2, 0) : mk(10, 1, 0))
						: (q.bit_static ? mk(12, 2, 0) : mk(8, 1, 0));
				else if (mem && q.size == sz_byte)
					c = q.bit_static ? mk(12, 2, 1) : mk(8, 1, 1);
			end
			op_bit_test: begin
				if (dreg && lng)
					c = q.bit_static ? mk(10, 2, 0) : mk(6, 1, 0);
				else if (mem && q.size == sz_byte)
					c = q.bit_static ? mk(8, 2, 0) : mk(4, 1, 0);
			end
			op_cond_branch: begin
				c = q.cond_true ? mk(10, 2, 0)
					: (q.disp_word ? mk(12, 2, 0) : mk(8, 1, 0));
			end
			op_unconditional_branch: c = mk(10, 2, 0);
			op_branch_to_subroutine: c = mk(18, 2, 2);
			op_decrement_loop_branch: begin
				c = q.cond_true ? mk(12, 2, 0)
					: (q.count_expired ? mk(14, 3, 0) : mk(10, 2, 0));
			end
			default: c = COST_NONE;
		endcase
		return c;
	endfunction : base_cost

	// Entries that take the operand locator figures on top of their base
	function automatic logic uses_locator(input req_t q);
		logic two_operand;
		two_operand = (q.op inside {op_sum, op_difference, op_conjunction, op_disjunction,
			op_compare, op_signed_divide, op_unsigned_divide,
			op_signed_multiply, op_unsigned_multiply});
		return (q.dest == dst_memory) || two_operand
			|| (q.op == op_exclusive && q.dest == dst_memory);
	endfunction : uses_locator

	wire logic [PATTERN_W-1:0] ones;
	wire logic [PATTERN_W-1:0] changes;

	bit_pattern_count #(
		.WIDTH (OPND_W),
		.CNT_W (PATTERN_W)
	) pattern_count (
		.operand (req.operand),
		.ones    (ones),
		.changes (changes)
	);

	wire logic is_signed_mul = (req.op == op_signed_multiply);
	wire logic is_mul        = is_signed_mul || (req.op == op_unsigned_multiply);
	wire logic is_div        = (req.op inside {op_signed_divide, op_unsigned_divide});
	wire logic [PATTERN_W-1:0] mul_n = is_signed_mul ? changes : ones;
	// Divide spread capped at 8 clocks, under a tenth of either worst case
	wire logic [PATTERN_W-1:0] div_trim =
		PATTERN_W'({ones[PATTERN_W-1:DIV_TRIM_SHIFT], 1'b0});
	wire cost_t base   = base_cost(req, int'(mul_n), int'(div_trim));
	wire logic  absent = (base.clocks == '0);
	wire cost_t total  = uses_locator(req) ? add_cost(base, locator_cost) : base;
	wire logic  take   = req_valid && req_ready;

	state_t                state;
	state_t                next_state;
	logic   [CLK_W-1:0]    remaining;
	logic   [CLK_W-1:0]    next_remaining;

	always_comb begin
		next_state     = state;
		next_remaining = remaining;
		case (state)
			st_idle: begin
				if (take) begin
					next_state     = absent ? st_done : st_run;
					next_remaining = absent ? '0 : total.clocks - CLK_W'(1);
				end
			end
			st_run: begin
				// Zero-wait bus assumed; stalls are not seen here
				if (remaining == '0)
					next_state = st_done;
				else
					next_remaining = remaining - CLK_W'(1);
			end
			st_done:  next_state = st_idle;
			default:  next_state = st_idle;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state     <= st_idle;
			remaining <= '0;
		end else begin
			state     <= next_state;
			remaining <= next_remaining;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			req_ready  <= 1'b0;
			busy       <= 1'b0;
			done       <= 1'b0;
		end else begin
			req_ready  <= (next_state == st_idle);
			busy       <= (next_state == st_run);
			done       <= (next_state == st_done);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cost       <= COST_NONE;
			illegal    <= 1'b0;
			duration_n <= '0;
		end else if (take) begin
			cost       <= absent ? COST_NONE : total;
			illegal    <= absent;
			duration_n <= (is_mul || is_div) ? mul_n : PATTERN_W'(req.shift_count);
		end
	end

	// A skipped entry completes straight from idle with its own zero cost
	wire logic  skip_tally = (state == st_idle) ? absent : illegal;
	wire cost_t done_cost  = (state == st_idle) ? total : cost;

	// Tallies grow when an instruction completes, so they match done
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tally <= '0;
		end else if (next_state == st_done && !skip_tally) begin
			tally.clocks <= tally.clocks + TALLY_W'(done_cost.clocks);
			tally.reads  <= tally.reads + TALLY_W'(done_cost.reads);
			tally.writes <= tally.writes + TALLY_W'(done_cost.writes);
		end
	end

endmodule : instruction_cycle_timing

// ---- bench/locator_source.sv ----
// Operand locator cost source standing in for the bus side of the core
module locator_source
	import cycle_timing_pkg::*;
(
	input  wire logic [1:0]            mode,
	output cycle_timing_pkg::cost_t    locator_cost
);
	timeunit 1ns;
	timeprecision 1ns;

	// Zero-wait bus: each locator read costs exactly one four-clock cycle
	always_comb begin
		case (mode)
			2'h1: locator_cost = '{clocks: 9'h004, reads: 4'h1, writes: 4'h0};
			2'h2: locator_cost = '{clocks: 9'h008, reads: 4'h2, writes: 4'h0};
			2'h3: locator_cost = '{clocks: 9'h00c, reads: 4'h3, writes: 4'h0};
			default: locator_cost = COST_NONE;
		endcase
	end
endmodule : locator_source

// ---- bench/cycle_timing_monitor.sv ----
// Concurrent checks on the ports of the instruction cycle timing engine
module cycle_timing_monitor
	import cycle_timing_pkg::*;
(
	input wire logic                                 sys_clk,
	input wire logic                                 rst,
	input wire logic                                 req_valid,
	input wire cycle_timing_pkg::req_t               req,
	input wire cycle_timing_pkg::cost_t              locator_cost,
	input wire logic                                 req_ready,
	input wire logic                                 busy,
	input wire logic                                 done,
	input wire logic                                 illegal,
	input wire cycle_timing_pkg::cost_t              cost,
	input wire logic [cycle_timing_pkg::PATTERN_W-1:0] duration_n,
	input wire cycle_timing_pkg::tally_t             tally
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [9:0] busy_len;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			busy_len <= 10'h000;
		else
			busy_len <= busy ? busy_len + 10'h001 : 10'h000;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_take; req_valid && req_ready; endsequence
	sequence s_rest; !done && req_ready; endsequence

	property p_take;
		s_take |=> !req_ready && (illegal ? (done && !busy) : (busy && !done));
	endproperty
	property p_done; done |=> s_rest; endproperty
	property p_busy_len; $fell(busy) |-> done && busy_len == 10'(cost.clocks); endproperty
	property p_tally;
		$rose(done) && !illegal |-> tally.clocks == $past(tally.clocks) + cost.clocks
			&& tally.writes == $past(tally.writes) + cost.writes;
	endproperty
	property p_mul_u;
		s_take ##0 req.op == op_unsigned_multiply |=> duration_n == $countones($past(req.operand));
	endproperty
	property p_mul_s;
		s_take ##0 req.op == op_signed_multiply
			|=> duration_n == $countones($past(req.operand) ^ ($past(req.operand) << 1));
	endproperty
	property p_mul_t;
		s_take ##0 req.op inside {op_signed_multiply, op_unsigned_multiply}
			|=> illegal || cost.clocks == 38 + 2 * duration_n + $past(locator_cost.clocks);
	endproperty
	property p_div;
		s_take ##0 req.op == op_signed_divide
			|=> illegal || (cost.clocks - $past(locator_cost.clocks)) inside {[143:158]};
	endproperty
	property p_div_u;
		s_take ##0 req.op == op_unsigned_divide
			|=> illegal || (cost.clocks - $past(locator_cost.clocks)) inside {[127:140]};
	endproperty
	property p_shift;
		s_take ##0 (req.op == op_shift_rotate && req.dest != dst_memory) |=> illegal
			|| cost.clocks == ($past(req.size) == sz_long ? 8 : 6) + 2 * $past(req.shift_count);
	endproperty

	a_take: assert property (p_take) else $error("take did not start the instruction");
	a_done: assert property (p_done) else $error("done not a single pulse");
	a_busy_len: assert property (p_busy_len) else $error("busy length differs");
	a_tally: assert property (p_tally) else $error("tally not advanced by cost");
	a_mul_u: assert property (p_mul_u) else $error("unsigned multiply count wrong");
	a_mul_s: assert property (p_mul_s) else $error("signed multiply count wrong");
	a_mul_t: assert property (p_mul_t) else $error("multiply duration wrong");
	a_div: assert property (p_div) else $error("signed divide outside its span");
	a_shift: assert property (p_shift) else $error("register shift duration wrong");
	a_div_u: assert property (p_div_u) else $error("unsigned divide outside its span");
endmodule : cycle_timing_monitor

bind instruction_cycle_timing cycle_timing_monitor cycle_timing_monitor_inst (
	.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
	.locator_cost(locator_cost), .req_ready(req_ready), .busy(busy), .done(done),
	.illegal(illegal), .cost(cost), .duration_n(duration_n), .tally(tally)
);

// ---- bench/tb.sv ----
// Self-checking bench for the instruction cycle timing engine
module tb import cycle_timing_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
		$display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end

	localparam int DLY = 10;
	localparam int N = 43;
	localparam size_t sb = sz_byte, sw = sz_word, sl = sz_long;
	localparam dest_t dd = dst_data_reg, da = dst_addr_reg, dm = dst_memory;

	// Flags: direct source, static, condition true, word displacement, expired
	typedef struct packed {
		op_t        op;
		size_t      sz;
		dest_t      dst;
		logic [4:0] f;
		logic [8:0] c;
		logic [3:0] r;
		logic [3:0] w;
	} row_t;

	logic        sys_clk, rst, req_valid, req_ready, busy, done, illegal;
	logic [1:0]  mode;
	req_t        req;
	cost_t       locator_cost, cost;
	tally_t      tally, et;
	logic [PATTERN_W-1:0] duration_n;
	int          err_count, total_checks, n;
	logic [15:0] vals [5] = '{16'h0000, 16'hffff, 16'h5555, 16'haaaa, 16'h8001};
	logic [5:0]  counts [3] = '{6'h00, 6'h1f, 6'h3f};

	row_t rows [N] = '{
		'{op_sum, sw, dd, 5'h00, 9'h004, 4'h1, 4'h0},
		'{op_disjunction, sl, dm, 5'h00, 9'h00c, 4'h1, 4'h2},
		'{op_conjunction, sb, dm, 5'h00, 9'h008, 4'h1, 4'h1},
		'{op_difference, sl, dd, 5'h00, 9'h006, 4'h1, 4'h0},
		'{op_sum, sl, da, 5'h10, 9'h008, 4'h1, 4'h0},
		'{op_sum, sw, da, 5'h00, 9'h008, 4'h1, 4'h0},
		'{op_compare, sw, da, 5'h00, 9'h006, 4'h1, 4'h0},
		'{op_compare, sl, dd, 5'h00, 9'h006, 4'h1, 4'h0},
		'{op_exclusive, sl, dd, 5'h10, 9'h008, 4'h1, 4'h0},
		'{op_exclusive, sw, dd, 5'h00, 9'h000, 4'h0, 4'h0},
		'{op_immediate_sum, sl, dd, 5'h00, 9'h010, 4'h3, 4'h0},
		'{op_immediate_exclusive, sl, dm, 5'h00, 9'h014, 4'h3, 4'h2},
		'{op_immediate_disjunction, sw, dm, 5'h00, 9'h00c, 4'h2, 4'h1},
		'{op_immediate_conjunction, sl, dd, 5'h00, 9'h00e, 4'h3, 4'h0},
		'{op_immediate_compare, sl, dm, 5'h00, 9'h00c, 4'h3, 4'h0},
		'{op_immediate_compare, sw, dm, 5'h00, 9'h008, 4'h2, 4'h0},
		'{op_quick_sum, sl, dd, 5'h00, 9'h008, 4'h1, 4'h0},
		'{op_quick_difference, sw, da, 5'h00, 9'h008, 4'h1, 4'h0},
		'{op_quick_sum, sw, da, 5'h00, 9'h004, 4'h1, 4'h0},
		'{op_quick_difference, sl, dm, 5'h00, 9'h00c, 4'h1, 4'h2},
		'{op_zero_fill, sl, dd, 5'h00, 9'h006, 4'h1, 4'h0},
		'{op_arith_minus, sw, dm, 5'h00, 9'h008, 4'h1, 4'h1},
		'{op_invert, sl, dm, 5'h00, 9'h00c, 4'h1, 4'h2},
		'{op_cond_set, sb, dd, 5'h04, 9'h006, 4'h1, 4'h0},
		'{op_cond_set, sb, dd, 5'h00, 9'h004, 4'h1, 4'h0},
		'{op_atomic_test_set, sb, dm, 5'h00, 9'h00e, 4'h2, 4'h1},
		'{op_test_against_zero, sl, dm, 5'h00, 9'h004, 4'h1, 4'h0},
		'{op_shift_rotate, sw, dm, 5'h00, 9'h008, 4'h1, 4'h1},
		'{op_shift_rotate, sl, dm, 5'h00, 9'h000, 4'h0, 4'h0},
		'{op_bit_change, sl, dd, 5'h00, 9'h008, 4'h1, 4'h0},
		'{op_bit_clear, sl, dd, 5'h08, 9'h00e, 4'h2, 4'h0},
		'{op_bit_test, sl, dd, 5'h00, 9'h006, 4'h1, 4'h0},
		'{op_bit_clear, sb, dm, 5'h08, 9'h00c, 4'h2, 4'h1},
		'{op_bit_test, sb, dm, 5'h08, 9'h008, 4'h2, 4'h0},
		'{op_cond_branch, sb, dd, 5'h02, 9'h00c, 4'h2, 4'h0},
		'{op_branch_to_subroutine, sb, dd, 5'h00, 9'h012, 4'h2, 4'h2},
		'{op_unconditional_branch, sb, dd, 5'h00, 9'h00a, 4'h2, 4'h0},
		'{op_cond_branch, sb, dd, 5'h00, 9'h008, 4'h1, 4'h0},
		'{op_decimal_minus, sb, dd, 5'h00, 9'h006, 4'h1, 4'h0},
		'{op_arith_minus_extend, sl, dd, 5'h00, 9'h006, 4'h1, 4'h0},
		'{op_immediate_difference, sw, dd, 5'h00, 9'h008, 4'h2, 4'h0},
		'{op_decrement_loop_branch, sb, dd, 5'h04, 9'h00c, 4'h2, 4'h0},
		'{op_decrement_loop_branch, sb, dd, 5'h01, 9'h00e, 4'h3, 4'h0}
	};

	instruction_cycle_timing instruction_cycle_timing_inst (
		.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
		.locator_cost(locator_cost), .req_ready(req_ready), .busy(busy), .done(done),
		.illegal(illegal), .cost(cost), .duration_n(duration_n), .tally(tally)
	);
	locator_source locator_source_inst (.mode(mode), .locator_cost(locator_cost));

	function automatic req_t mk(op_t o, size_t s, dest_t d, logic [4:0] f, logic [5:0] c,
		logic [15:0] v);
		mk = '{o, s, d, f[4], f[3], f[2], f[1], f[0], c, v};
	endfunction : mk

	task automatic conclude();
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// Issue once ready, then wait for the end pulse and check it
	task automatic run(input req_t r, input logic [1:0] m, input logic [8:0] c,
		input logic [3:0] rd, input logic [3:0] wr);
		int k;
		req = r;
		mode = m;
		req_valid = 1'b1;
		k = 0;
		while (req_ready !== 1'b1 && k < 500) begin
			@(posedge sys_clk);
			#DLY;
			k++;
		end
		@(posedge sys_clk);
		#DLY;
		req_valid = 1'b0;
		while (done !== 1'b1 && k < 500) begin
			@(posedge sys_clk);
			#DLY;
			k++;
		end
		if (c != 9'h000)
			et = '{et.clocks + c, et.reads + rd, et.writes + wr};
		`CHK(done, 1'b1)
		`CHK(cost, {c, rd, wr})
		`CHK(illegal, c == 9'h000)
		`CHK(tally, et)
	endtask : run

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	// Whole run is about three thousand cycles; over six times that means a hang
	initial begin
		#2_000_000;
		err_count++;
		conclude();
	end

	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		mode = 2'h0;
		et = '0;
		repeat (8) @(posedge sys_clk);
		#DLY;
		`CHK(req_ready, 1'b0)
		`CHK(tally, et)
		rst = 1'b0;
		@(posedge sys_clk);
		#DLY;
		`CHK(req_ready, 1'b1)
		foreach (rows[i])
			run(mk(rows[i].op, rows[i].sz, rows[i].dst, rows[i].f, 6'h00, 16'h0000), 2'h0,
				rows[i].c, rows[i].r, rows[i].w);
		for (int s = 0; s < 2; s++) begin
			foreach (counts[j]) begin
				run(mk(op_shift_rotate, s ? sl : sw, dd, 5'h00, counts[j], 16'h0000), 2'h0,
					9'((s ? 8 : 6) + 2 * counts[j]), 4'h1, 4'h0);
				`CHK(duration_n, counts[j][4:0])
			end
		end
		foreach (vals[j]) begin
			n = $countones(vals[j]);
			run(mk(op_unsigned_multiply, sw, dd, 5'h10, 6'h00, vals[j]), 2'h0,
				9'(38 + 2 * n), 4'h1, 4'h0);
			`CHK(duration_n, 5'(n))
			n = $countones(vals[j] ^ (vals[j] << 1));
			run(mk(op_signed_multiply, sw, dd, 5'h10, 6'h00, vals[j]), 2'h0,
				9'(38 + 2 * n), 4'h1, 4'h0);
			`CHK(duration_n, 5'(n))
			n = $countones(vals[j]) / 4;
			run(mk(op_signed_divide, sw, dd, 5'h10, 6'h00, vals[j]), 2'h1,
				9'(162 - 2 * n), 4'h2, 4'h0);
			run(mk(op_unsigned_divide, sw, dd, 5'h10, 6'h00, vals[j]), 2'h1,
				9'(144 - 2 * n), 4'h2, 4'h0);
		end
		run(mk(op_sum, sw, dm, 5'h00, 6'h00, 16'h0000), 2'h2, 9'h010, 4'h3, 4'h1);
		run(mk(op_exclusive, sl, dd, 5'h10, 6'h00, 16'h0000), 2'h3, 9'h008, 4'h1, 4'h0);
		// Reset in mid-divide must drop the count and the tallies
		@(posedge sys_clk);
		#DLY;
		req = mk(op_signed_divide, sw, dd, 5'h10, 6'h00, 16'h0000);
		req_valid = 1'b1;
		@(posedge sys_clk);
		#DLY;
		req_valid = 1'b0;
		repeat (20) @(posedge sys_clk);
		#DLY;
		`CHK(busy, 1'b1)
		rst = 1'b1;
		et = '0;
		#DLY;
		`CHK(busy, 1'b0)
		`CHK(tally, et)
		@(posedge sys_clk);
		#DLY;
		rst = 1'b0;
		run(mk(op_quick_load, sl, dd, 5'h00, 6'h00, 16'h0000), 2'h0, 9'h004, 4'h1, 4'h0);
		conclude();
	end
endmodule : tb
